// >>> hdl/signed_dual_halfword_mac_unit.sv
// Chosen here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
`include "mac_unit_defs.svh"
module signed_dual_halfword_mac_unit (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // interrupt
  output logic             irq
);
  // ====================
  // bus phase capture
  mac_unit_pkg::bus_phase_t dph;
  mac_unit_pkg::bus_phase_t next_dph;

  always_comb begin
    next_dph.valid = hsel & hready & htrans[1];
    next_dph.write = hwrite;
    next_dph.addr  = haddr[7:0];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dph <= '0;
    end else begin
      dph <= next_dph;
    end
  end

  // single-cycle datapath, so the slave never stalls
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ====================
  // register file
  logic [3:0]  cmd;
  logic [31:0] src1, src2, accIn, accLo, accHi, dest, app_status_reg;
  logic [`EV_WIDTH-1:0] evStat, evMask;
  logic [3:0]  next_cmd;
  logic [31:0] next_src1, next_src2, next_accIn, next_accLo;
  logic [31:0] next_accHi, next_dest, next_app_status_reg;
  logic [`EV_WIDTH-1:0] next_evStat, next_evMask;
  logic        wrEn, start;
  logic [`EV_WIDTH-1:0] ev;
  mac_unit_pkg::mac_res_t res;

  assign wrEn  = dph.valid & dph.write;
  assign start = wrEn && (dph.addr == `OFS_CMD);

  // ====================
  // datapath
  mac_unit_pkg::mac_op_t op;
  logic               crossed, isSub, isLong;
  logic        [31:0] bsw;
  logic        [15:0] pickA, pickB;
  logic signed [31:0] p0, p1, pHalf;
  logic signed [32:0] pair;
  logic signed [63:0] pWord, addend, acc64, sum64;
  logic        [32:0] sum33;
  logic               ov32, ov64;

  always_comb begin
    op = mac_unit_pkg::mac_op_t'(hwdata[3:0]);
    crossed = (op == mac_unit_pkg::DUAL_MAC32_CROSSED) ||
              (op == mac_unit_pkg::LONG_DUAL_MAC_CROSS) ||
              (op == mac_unit_pkg::DUAL_MSUB32_CROSSED) ||
              (op == mac_unit_pkg::LONG_DUAL_MSUB_CROS);
    isSub = (op == mac_unit_pkg::DUAL_MSUB32) ||
            (op == mac_unit_pkg::DUAL_MSUB32_CROSSED) ||
            (op == mac_unit_pkg::LONG_DUAL_MSUB) ||
            (op == mac_unit_pkg::LONG_DUAL_MSUB_CROS);
    isLong = !((op == mac_unit_pkg::DUAL_MAC32) ||
               (op == mac_unit_pkg::DUAL_MAC32_CROSSED) ||
               (op == mac_unit_pkg::DUAL_MSUB32) ||
               (op == mac_unit_pkg::DUAL_MSUB32_CROSSED));
    // crossing is a halfword swap of the second source
    bsw = crossed ? {src2[15:0], src2[31:16]} : src2;
    p0 = $signed(src1[15:0]) * $signed(bsw[15:0]);
    p1 = $signed(src1[31:16]) * $signed(bsw[31:16]);
    // 33 bits: two products of -32768 squared overflow 32
    pair = isSub ? ({p0[31], p0} - {p1[31], p1})
                 : ({p0[31], p0} + {p1[31], p1});
    pickA = (op == mac_unit_pkg::LONG_HALF_HL ||
             op == mac_unit_pkg::LONG_HALF_HH) ? src1[31:16] : src1[15:0];
    pickB = (op == mac_unit_pkg::LONG_HALF_LH ||
             op == mac_unit_pkg::LONG_HALF_HH) ? src2[31:16] : src2[15:0];
    pHalf = $signed(pickA) * $signed(pickB);
    pWord = $signed(src1) * $signed(src2);
    acc64 = {accHi, accLo};
    unique case (op)
      mac_unit_pkg::LONG_WORD_MAC: addend = pWord;
      mac_unit_pkg::LONG_HALF_LL,
      mac_unit_pkg::LONG_HALF_LH,
      mac_unit_pkg::LONG_HALF_HL,
      mac_unit_pkg::LONG_HALF_HH: addend = {{32{pHalf[31]}}, pHalf};
      default: addend = {{31{pair[32]}}, pair};
    endcase
    sum64 = acc64 + addend;
    ov64  = (acc64[63] == addend[63]) && (sum64[63] != acc64[63]);
    // difference of two products always fits 32 bits
    sum33 = {accIn[31], accIn} + {pair[31], pair[31:0]};
    ov32  = sum33[32] != sum33[31];
    res.dest   = sum33[31:0];
    res.acc    = sum64;
    res.bad    = hwdata[3:0] > 4'hC;
    res.wrDest = !isLong && !res.bad;
    res.wrAcc  = isLong && !res.bad;
    // additions of the add forms leave the saturation flag alone
    res.sat    = isSub && !res.bad && (isLong ? ov64 : ov32);
  end

  // ====================
  // next register values
  always_comb begin
    next_cmd    = cmd;
    next_src1   = src1;
    next_src2   = src2;
    next_accIn  = accIn;
    next_accLo  = accLo;
    next_accHi  = accHi;
    next_dest   = dest;
    next_app_status_reg   = app_status_reg;
    next_evMask = evMask;
    next_evStat = evStat;
    if (wrEn) begin
      unique case (dph.addr)
        `OFS_CMD:     next_cmd    = hwdata[3:0];
        `OFS_SRC1:    next_src1   = hwdata;
        `OFS_SRC2:    next_src2   = hwdata;
        `OFS_ACCIN:   next_accIn  = hwdata;
        `OFS_ACCLO:   next_accLo  = hwdata;
        `OFS_ACCHI:   next_accHi  = hwdata;
        `OFS_APP_STATUS_REG:    next_app_status_reg   = hwdata;
        `OFS_IRQSTAT: next_evStat = evStat & ~hwdata[`EV_WIDTH-1:0];
        `OFS_IRQMASK: next_evMask = hwdata[`EV_WIDTH-1:0];
        default:      next_cmd    = cmd;
      endcase
    end
    if (start && res.wrDest) begin
      next_dest = res.dest;
    end
    if (start && res.wrAcc) begin
      next_accLo = res.acc[31:0];
      next_accHi = res.acc[63:32];
    end
    // only the saturation bit moves; other flags stay as written
    if (start && res.sat) begin
      next_app_status_reg[`APP_STATUS_REG_Q_BIT] = 1'b1;
    end
    // set wins over a write-one clear in the same cycle
    next_evStat = next_evStat | ev;
  end

  always_comb begin
    ev = '0;
    ev[`EV_DONE_BIT] = start && !res.bad;
    ev[`EV_SAT_BIT]  = start && res.sat;
    ev[`EV_BAD_BIT]  = start && res.bad;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cmd    <= 4'h0;
      src1   <= `RST_WORD;
      src2   <= `RST_WORD;
      accIn  <= `RST_WORD;
      accLo  <= `RST_WORD;
      accHi  <= `RST_WORD;
      dest   <= `RST_WORD;
      app_status_reg   <= `RST_WORD;
      evStat <= `RST_EV;
      evMask <= `RST_EV;
    end else begin
      cmd    <= next_cmd;
      src1   <= next_src1;
      src2   <= next_src2;
      accIn  <= next_accIn;
      accLo  <= next_accLo;
      accHi  <= next_accHi;
      dest   <= next_dest;
      app_status_reg   <= next_app_status_reg;
      evStat <= next_evStat;
      evMask <= next_evMask;
    end
  end

  assign irq = |(evStat & evMask);

  // ====================
  // read mux
  always_comb begin
    hrdata = 32'h0000_0000;
    if (dph.valid && !dph.write) begin
      unique case (dph.addr)
        `OFS_CMD:     hrdata = {28'h000_0000, cmd};
        `OFS_SRC1:    hrdata = src1;
        `OFS_SRC2:    hrdata = src2;
        `OFS_ACCIN:   hrdata = accIn;
        `OFS_ACCLO:   hrdata = accLo;
        `OFS_ACCHI:   hrdata = accHi;
        `OFS_DEST:    hrdata = dest;
        `OFS_APP_STATUS_REG:    hrdata = app_status_reg;
        `OFS_IRQSTAT: hrdata = {29'h0000_0000, evStat};
        `OFS_IRQMASK: hrdata = {29'h0000_0000, evMask};
        default:      hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ====================
  // checks
  logic [3:0] sOp;
  assign sOp = hwdata[3:0];

  a_dual_straight: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h0 |=> dest == $past(accIn)
      + 32'($signed($past(src1[15:0])) * $signed($past(src2[15:0])))
      + 32'($signed($past(src1[31:16])) * $signed($past(src2[31:16]))))
    else $error("dual mac result wrong");

  a_dual_cross: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h1 |=> dest == $past(accIn)
      + 32'($signed($past(src1[15:0])) * $signed($past(src2[31:16])))
      + 32'($signed($past(src1[31:16])) * $signed($past(src2[15:0]))))
    else $error("crossed dual mac result wrong");

  a_flags_kept: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp < 4'h9 |=> $stable(app_status_reg))
    else $error("add form changed flags");

  a_long_word: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h2 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($signed($past(src1)) * $signed($past(src2))))
    else $error("long word mac result wrong");

  a_half_hh: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h6 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($signed($past(src1[31:16])) * $signed($past(src2[31:16]))))
    else $error("high high half mac wrong");

  a_msub32: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h9 |=> dest == $past(accIn)
      + 32'($signed($past(src1[15:0])) * $signed($past(src2[15:0])))
      - 32'($signed($past(src1[31:16])) * $signed($past(src2[31:16]))))
    else $error("dual msub result wrong");

  a_long_keep_dest: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp inside {[4'h2:4'h8]} |=> $stable(dest) && $stable(accIn))
    else $error("long form touched destination");

  // one cycle only: software may rewrite the status word right after
  a_q_sticky: assert property (@(posedge ref_clk) disable iff (!resetn)
    app_status_reg[`APP_STATUS_REG_Q_BIT] && !(wrEn && dph.addr == `OFS_APP_STATUS_REG)
      |=> app_status_reg[`APP_STATUS_REG_Q_BIT])
    else $error("saturation flag dropped");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && res.sat && evMask[`EV_SAT_BIT]
      && !(wrEn && dph.addr == `OFS_IRQMASK) |=> irq)
    else $error("interrupt missing after saturation");

  // ====================
  // independent products for the checks below
  logic signed [31:0] llProd, hhProd, lhProd, hlProd;
  logic signed [63:0] wideSub, wideSubX;

  assign llProd = $signed(src1[15:0]) * $signed(src2[15:0]);
  assign hhProd = $signed(src1[31:16]) * $signed(src2[31:16]);
  assign lhProd = $signed(src1[15:0]) * $signed(src2[31:16]);
  assign hlProd = $signed(src1[31:16]) * $signed(src2[15:0]);
  // wide sums show a 32-bit accumulate overflow as disagreeing upper bits
  assign wideSub  = 64'($signed(accIn)) + 64'(llProd) - 64'(hhProd);
  assign wideSubX = 64'($signed(accIn)) + 64'(lhProd) - 64'(hlProd);

  a_half_ll: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h3 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(llProd)))
    else $error("low low half mac wrong");

  a_half_lh: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h4 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(lhProd)))
    else $error("low high half mac wrong");

  a_half_hl: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h5 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(hlProd)))
    else $error("high low half mac wrong");

  a_long_dual: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h7 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(llProd)) + 64'($past(hhProd)))
    else $error("long dual mac wrong");

  a_long_dual_x: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h8 |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(lhProd)) + 64'($past(hlProd)))
    else $error("crossed long dual mac wrong");

  a_msub32_x: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'hA |=> dest == $past(wideSubX[31:0]))
    else $error("crossed dual msub result wrong");

  a_long_msub: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'hB |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(llProd)) - 64'($past(hhProd)))
    else $error("long dual msub wrong");

  a_long_msub_x: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'hC |=> {accHi, accLo} == $past({accHi, accLo})
      + 64'($past(lhProd)) - 64'($past(hlProd)))
    else $error("crossed long dual msub wrong");

  a_q_on_ovf: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h9 && wideSub[63:31] != {33{wideSub[31]}}
      |=> app_status_reg[`APP_STATUS_REG_Q_BIT])
    else $error("saturation flag not set on overflow");

  a_q_no_ovf: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp == 4'h9 && !app_status_reg[`APP_STATUS_REG_Q_BIT] && wideSub[63:31] == {33{wideSub[31]}}
      |=> !app_status_reg[`APP_STATUS_REG_Q_BIT])
    else $error("saturation flag set without overflow");

  a_dual_keep_acc: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp inside {4'h0, 4'h1, 4'h9, 4'hA} |=> $stable({accHi, accLo}))
    else $error("32-bit form touched accumulator pair");

  a_bad_op: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp > 4'hC |=> evStat[`EV_BAD_BIT] && $stable(dest)
      && $stable({accHi, accLo}) && $stable(app_status_reg))
    else $error("bad op code produced a result");

  a_done_event: assert property (@(posedge ref_clk) disable iff (!resetn)
    start && sOp <= 4'hC |=> evStat[`EV_DONE_BIT])
    else $error("done event missing");

  a_stat_w1c: assert property (@(posedge ref_clk) disable iff (!resetn)
    wrEn && dph.addr == `OFS_IRQSTAT |=> (evStat & $past(hwdata[`EV_WIDTH-1:0])) == 3'h0)
    else $error("status bit not cleared by write");

  c_dual_mac: cover property (@(posedge ref_clk) start && sOp == 4'h0);
  c_bad_op: cover property (@(posedge ref_clk) start && sOp > 4'hC);
  c_long_msub: cover property (@(posedge ref_clk) start && sOp == 4'hB);
  c_sat_set: cover property (@(posedge ref_clk) start && res.sat);
  c_irq_up: cover property (@(posedge ref_clk) $rose(irq));
endmodule : signed_dual_halfword_mac_unit

// >>> hdl/mac_unit_defs.svh
`ifndef MAC_UNIT_DEFS_SVH
`define MAC_UNIT_DEFS_SVH
// ====================
// register byte offsets
`define OFS_CMD     8'h00
`define OFS_SRC1    8'h04
`define OFS_SRC2    8'h08
`define OFS_ACCIN   8'h0C
`define OFS_ACCLO   8'h10
`define OFS_ACCHI   8'h14
`define OFS_DEST    8'h18
`define OFS_APP_STATUS_REG    8'h1C
`define OFS_IRQSTAT 8'h20
`define OFS_IRQMASK 8'h24
// ====================
// field positions
`define APP_STATUS_REG_Q_BIT  27
`define EV_DONE_BIT 0
`define EV_SAT_BIT  1
`define EV_BAD_BIT  2
`define EV_WIDTH    3
// ====================
// reset values
`define RST_WORD    32'h0000_0000
`define RST_EV      3'h0
`endif

// >>> hdl/mac_unit_pkg.sv
package mac_unit_pkg;
  // ====================
  // operation codes
  typedef enum logic [3:0] {
    DUAL_MAC32          = 4'h0,
    DUAL_MAC32_CROSSED  = 4'h1,
    LONG_WORD_MAC       = 4'h2,
    LONG_HALF_LL        = 4'h3,
    LONG_HALF_LH        = 4'h4,
    LONG_HALF_HL        = 4'h5,
    LONG_HALF_HH        = 4'h6,
    LONG_DUAL_MAC       = 4'h7,
    LONG_DUAL_MAC_CROSS = 4'h8,
    DUAL_MSUB32         = 4'h9,
    DUAL_MSUB32_CROSSED = 4'hA,
    LONG_DUAL_MSUB      = 4'hB,
    LONG_DUAL_MSUB_CROS = 4'hC
  } mac_op_t;

  // ====================
  // datapath result carrier
  typedef struct packed {
    logic [31:0] dest;
    logic [63:0] acc;
    logic        wrDest;
    logic        wrAcc;
    logic        sat;
    logic        bad;
  } mac_res_t;

  // ====================
  // captured address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } bus_phase_t;
endpackage : mac_unit_pkg

// >>> verif/mac_issuer_model.sv
`timescale 1ns/100ps
// ====================
// issuing side: single-word ahb-lite master
module mac_issuer_model (
  // clock
  input  wire logic        ref_clk,
  // ahb-lite master
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // ====================
  // one transfer
  // operands sit at fixed offsets, so the two accumulator halves never alias
  task automatic xfer(input bit w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output bit ok);
    int n;
    n = 0;
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= w;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    htrans <= 2'b00;
    // reads: flip the lines so stale data never looks valid
    hwdata <= w ? d : ~hwdata;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hready !== 1'b1 && n < 40);
    q  = hrdata;
    ok = (hready === 1'b1);
  endtask : xfer
endmodule : mac_issuer_model

// >>> verif/signed_dual_halfword_mac_unit_test.sv
`timescale 1ns/100ps
`include "mac_unit_defs.svh"
`define CHK(got, exp, what) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("wrong value at %0t: %s", $time, what); \
    end \
  end
module signed_dual_halfword_mac_unit_test;
  // ====================
  // bench signals
  logic        ref_clk, resetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          mismatches, samplesChecked, seed;
  logic [31:0] src1, src2, accIn, dest, app_status_reg;
  logic [63:0] acc;
  logic [2:0]  stat, mask;
  bit          ok;

  signed_dual_halfword_mac_unit signed_dual_halfword_mac_unit_i (
    .ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .irq(irq));
  mac_issuer_model mac_issuer_model_i (
    .ref_clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ====================
  // closing and bus tasks
  task automatic wrap_up();
    $display("checked %0d values, %0d wrong", samplesChecked, mismatches);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic xfer_chk(input bit w, input logic [7:0] a, input logic [31:0] d,
                          input logic [31:0] e, input string what);
    logic [31:0] q;
    mac_issuer_model_i.xfer(w, a, d, q, ok);
    if (!ok) begin
      mismatches++;
      wrap_up();
    end else begin
      if (!w) `CHK(q, e, what)
      `CHK(hresp, 1'b0, "response")
    end
  endtask : xfer_chk

  // ====================
  // reference model of one operation
  task automatic model_op(input logic [3:0] op);
    longint      a0, a1, b0, b1, p0, p1, s;
    logic [63:0] sum;
    bit          ov;
    a0 = $signed(src1[15:0]);
    a1 = $signed(src1[31:16]);
    b0 = $signed(src2[15:0]);
    b1 = $signed(src2[31:16]);
    ov = 1'b0;
    stat = (op > 4'hC) ? 3'b100 : 3'b001;
    if (op inside {4'h1, 4'h8, 4'hA, 4'hC}) begin
      s  = b0;
      b0 = b1;
      b1 = s;
    end
    p0 = a0 * b0;
    p1 = a1 * b1;
    case (op)
      4'h0, 4'h1: dest = 32'(accIn + p0 + p1);
      4'h2: acc = acc + longint'($signed(src1)) * longint'($signed(src2));
      4'h3: acc = acc + a0 * b0;
      4'h4: acc = acc + a0 * b1;
      4'h5: acc = acc + a1 * b0;
      4'h6: acc = acc + a1 * b1;
      4'h7, 4'h8: acc = acc + p0 + p1;
      4'h9, 4'hA: begin
        s    = longint'($signed(accIn)) + p0 - p1;
        dest = s[31:0];
        ov   = s != longint'(int'(s));
      end
      4'hB, 4'hC: begin
        s   = p0 - p1;
        sum = acc + s;
        ov  = acc[63] == s[63] && sum[63] != acc[63];
        acc = sum;
      end
      default: ;
    endcase
    if (ov) begin
      app_status_reg[`APP_STATUS_REG_Q_BIT] = 1'b1;
      stat[`EV_SAT_BIT] = 1'b1;
    end
  endtask : model_op

  // ====================
  // main sequence
  initial begin
    resetn = 1'b0;
    mismatches = 0;
    samplesChecked = 0;
    seed = 32'h0000_1125;
    dest = 32'h0000_0000;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a <= 8'h40; a += 4) xfer_chk(0, 8'(a), 0, 0, "reset value");
    xfer_chk(1, 8'h40, 32'hFFFF_FFFF, 0, "");
    xfer_chk(0, 8'h40, 0, 32'h0000_0000, "unmapped");
    // pass 0 uses corner operands that overflow every subtract form
    for (int k = 0; k < 4; k++) begin
      for (int op = 0; op < 16; op++) begin
        src1  = k == 0 ? 32'h7FFF_8000 : $random(seed);
        src2  = k == 0 ? 32'h8000_8000 : $random(seed);
        accIn = k == 0 ? 32'h7FFF_FFFF : $random(seed);
        acc   = k == 0 ? 64'h7FFF_FFFF_FFFF_FFFF : {$random(seed), $random(seed)};
        app_status_reg  = $random(seed);
        app_status_reg[`APP_STATUS_REG_Q_BIT] = k[0];
        mask  = 3'($random(seed));
        xfer_chk(1, `OFS_SRC1, src1, 0, "");
        xfer_chk(1, `OFS_SRC2, src2, 0, "");
        xfer_chk(1, `OFS_ACCIN, accIn, 0, "");
        xfer_chk(1, `OFS_ACCLO, acc[31:0], 0, "");
        xfer_chk(1, `OFS_ACCHI, acc[63:32], 0, "");
        xfer_chk(1, `OFS_APP_STATUS_REG, app_status_reg, 0, "");
        xfer_chk(1, `OFS_IRQMASK, {29'h0000_0000, mask}, 0, "");
        xfer_chk(1, `OFS_CMD, {28'h000_0000, op[3:0]}, 0, "");
        model_op(op[3:0]);
        // destination is read-only: this write must not stick
        xfer_chk(1, `OFS_DEST, ~dest, 0, "");
        xfer_chk(0, `OFS_DEST, 0, dest, "dest");
        xfer_chk(0, `OFS_ACCLO, 0, acc[31:0], "acc lower");
        xfer_chk(0, `OFS_ACCHI, 0, acc[63:32], "acc upper");
        xfer_chk(0, `OFS_APP_STATUS_REG, 0, app_status_reg, "status word");
        xfer_chk(0, `OFS_IRQSTAT, 0, {29'h0000_0000, stat}, "events");
        `CHK(irq, |(stat & mask), "irq level")
        xfer_chk(1, `OFS_IRQSTAT, 32'h0000_0007, 0, "");
        @(negedge ref_clk);
        `CHK(irq, 1'b0, "irq after clear")
        @(posedge ref_clk);
      end
    end
    wrap_up();
  end
endmodule : signed_dual_halfword_mac_unit_test
